// *** inc/cg3_pkg.sv ***
/*
  Constants, field layouts and the control write carrier for the
  third sample-clock generator. Assumes a 16-bit control word path.
*/
`default_nettype none
package cg3_pkg;
  // ---------------------------------------------------------------
  // Register addresses and masks
  // ---------------------------------------------------------------
  localparam logic [4:0]  ADDR_RATE_MOD  = 5'h16;
  localparam logic [4:0]  ADDR_RATE_HZ   = 5'h17;
  localparam logic [4:0]  ADDR_PHASE     = 5'h18;
  localparam logic [15:0] RST_RATE_MOD   = 16'h00ff;
  localparam logic [15:0] RST_RATE_HZ    = 16'hbb80;
  localparam logic [8:0]  RST_PHASE      = 9'h000;
  localparam logic [15:0] MASK_RATE_MOD  = 16'hc0ff;
  localparam int          BIT_REF        = 15;
  localparam int          BIT_VID        = 14;
  localparam int          BIT_STD        = 7;
  localparam int          BIT_DIR        = 8;
  // ---------------------------------------------------------------
  // Base rates in hertz for video lock
  // ---------------------------------------------------------------
  localparam logic [15:0] HZ_48000       = 16'hbb80;
  localparam logic [15:0] HZ_32000       = 16'h7d00;
  localparam logic [15:0] HZ_44100       = 16'hac44;
  localparam logic [15:0] HZ_29400       = 16'h72d8;
  localparam logic [15:0] HZ_47952       = 16'hbb50;
  localparam logic [15:0] HZ_44056       = 16'hac18;
  // ---------------------------------------------------------------
  // Crystal and phase timing
  // ---------------------------------------------------------------
  localparam int          XTAL_HZ_INT    = 24576000;
  localparam int          PHASE_HZ_INT   = 3072000;
  localparam int          PHASE_DIV_INT  = XTAL_HZ_INT / PHASE_HZ_INT;
  localparam logic [2:0]  PHASE_LAST     = 3'(PHASE_DIV_INT - 1);
  localparam logic [25:0] XTAL_HZ        = 26'(XTAL_HZ_INT);
  localparam logic [25:0] PH_STEP        = 26'(XTAL_HZ_INT / 3000);
  localparam logic [25:0] ACC_ZERO       = 26'h0000000;
  localparam logic [2:0]  CNT_ZERO       = 3'h0;
  localparam logic [2:0]  CNT_ONE        = 3'h1;
  localparam logic [7:0]  MAG_ZERO       = 8'h00;
  localparam logic [7:0]  MAG_ONE        = 8'h01;
  localparam logic [15:0] WORD_ZERO      = 16'h0000;

  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] data;
  } ctrl_wr_t;
endpackage
`default_nettype wire

// *** hw/sample_clock_gen.sv ***
/*
  Rate, video-lock selection and phase control of the third
  sample-clock generator, with control register write, read and
  write-echo handling. Assumes the serial framing logic outside
  delivers decoded writes, slot strobes and one crystal tick per
  crystal period, all synchronous to clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module sample_clock_gen #(
  parameter int ACC_W = 26
) (
  // Clock, reset and freeze
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  // Device pins and enables
  input  wire logic              reset_pin_n_in,
  input  wire logic              power_down_pin_n_in,
  input  wire logic              generator_enable_in,
  input  wire logic              crystal_clock_input_in,
  // Frame timing
  input  wire logic              bus_master_in,
  input  wire logic              slot0_start_in,
  input  wire logic              time_slot_input_pulse_in,
  input  wire logic              slot1_in,
  // Control access
  input  wire cg3_pkg::ctrl_wr_t ctrl_in,
  input  wire logic [4:0]        rd_addr_in,
  output logic [15:0]            rd_data_out,
  output logic [15:0]            echo_data_out,
  output logic                   echo_valid_out,
  // Generator outputs
  output logic                   conv_pulse_out,
  output logic                   lock_mode_out
);
  import cg3_pkg::*;
  if (ACC_W != 26) begin : g_bad_width
    $error("ACC_W must be 26");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] base_hz(
    input logic       pal,
    input logic [2:0] code
  );
    logic [15:0] hz;
    hz = HZ_48000;
    unique case (code)
      3'h1: hz = HZ_32000;
      3'h2: hz = HZ_44100;
      3'h3: hz = HZ_29400;
      3'h4: hz = pal ? HZ_48000 : HZ_47952;
      3'h5: hz = pal ? HZ_48000 : HZ_44056;
      default: hz = HZ_48000;
    endcase
    return hz;
  endfunction

  function automatic logic [15:0] reg_value(
    input logic [4:0]  addr,
    input logic [15:0] mod,
    input logic [15:0] rate,
    input logic [8:0]  phase
  );
    logic [15:0] v;
    v = WORD_ZERO;
    if (addr == ADDR_RATE_MOD) begin
      v = mod;
    end else if (addr == ADDR_RATE_HZ) begin
      v = rate;
    end else if (addr == ADDR_PHASE) begin
      v = {7'h00, phase};
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] rate_mod_ff;
  logic [15:0] rate_hz_ff;
  logic [8:0]  phase_ff;
  logic [8:0]  phase_snap_ff;
  logic [25:0] acc_ff;
  logic [2:0]  pre_ff;
  logic [2:0]  div_cnt_ff;
  logic [15:0] echo_hold_ff;
  logic        echo_pend_ff;
  logic [15:0] rd_data_ff;
  logic [15:0] echo_data_ff;
  logic        echo_valid_ff;
  logic        conv_ff;
  logic        lock_ff;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire logic hold_all = rst_in | ~reset_pin_n_in | ~power_down_pin_n_in;
  wire logic hold_ph  = hold_all | ~generator_enable_in;
  wire logic wr_mod   = ctrl_in.wr & (ctrl_in.addr == ADDR_RATE_MOD);
  wire logic wr_rate  = ctrl_in.wr & (ctrl_in.addr == ADDR_RATE_HZ);
  wire logic wr_ph    = ctrl_in.wr & (ctrl_in.addr == ADDR_PHASE);
  wire logic any_wr   = ctrl_in.wr;
  // Slot 0 start when master, time-slot pulse when slave.
  wire logic frame_mark = bus_master_in ? slot0_start_in
                                        : time_slot_input_pulse_in;

  wire logic video = rate_mod_ff[BIT_REF] & rate_mod_ff[BIT_VID];
  wire logic pal_std = rate_mod_ff[BIT_STD];
  wire logic [2:0] base_rate_code = rate_mod_ff[6:4];
  // Divisor codes above 0111 are undefined; the top bit is ignored.
  wire logic [2:0] divisor_code = rate_mod_ff[2:0];
  wire logic [7:0] phase_magnitude = phase_ff[7:0];
  wire logic phase_direction = phase_ff[BIT_DIR];

  // base rate feeds the accumulator in video mode
  wire logic [15:0] step_hz = video ? base_hz(pal_std, base_rate_code)
                                    : rate_hz_ff;

  // one unit per eighth crystal tick
  wire logic ph_tick = crystal_clock_input_in & (pre_ff == PHASE_LAST);
  wire logic ph_apply = ph_tick & (phase_magnitude != MAG_ZERO);

  // ---------------------------------------------------------------
  // Rate accumulator
  // ---------------------------------------------------------------
  // One step of the accumulator per crystal tick; a wrap past the
  // crystal rate makes a base pulse, so step_hz is exact in hertz.
  wire logic [25:0] acc_add = acc_ff + {10'h000, step_hz};
  // advance adds, retard subtracts one phase unit
  wire logic [25:0] acc_adv = acc_add + PH_STEP;
  wire logic        ret_ok  = acc_add >= PH_STEP;
  wire logic [25:0] acc_ret = ret_ok ? acc_add - PH_STEP : ACC_ZERO;
  wire logic [25:0] acc_sum = !ph_apply ? acc_add
                            : phase_direction ? acc_ret : acc_adv;
  wire logic        wrap    = acc_sum >= XTAL_HZ;
  wire logic [25:0] nxt_acc = wrap ? acc_sum - XTAL_HZ : acc_sum;
  wire logic        base_pulse = crystal_clock_input_in & wrap;

  wire logic div_hit  = div_cnt_ff == divisor_code;
  wire logic conv_now = base_pulse & (!video | div_hit);
  wire logic [2:0] nxt_div_cnt = !base_pulse ? div_cnt_ff
                               : (!video | div_hit) ? CNT_ZERO
                               : div_cnt_ff + CNT_ONE;

  // ---------------------------------------------------------------
  // Register next values
  // ---------------------------------------------------------------
  wire logic [15:0] nxt_rate_mod = wr_mod ? (ctrl_in.data & MASK_RATE_MOD)
                                          : rate_mod_ff;
  wire logic [15:0] nxt_rate_hz  = wr_rate ? ctrl_in.data : rate_hz_ff;
  // a write replaces whatever is left
  wire logic [8:0]  nxt_phase = wr_ph ? ctrl_in.data[8:0]
                              : ph_apply ? {phase_direction,
                                            phase_magnitude - MAG_ONE}
                              : phase_ff;
  wire logic [15:0] prior = reg_value(ctrl_in.addr, rate_mod_ff,
                                      rate_hz_ff, phase_ff);
  // reads of the phase register show the frame snapshot
  wire logic [15:0] nxt_rd_data = reg_value(rd_addr_in, rate_mod_ff,
                                            rate_hz_ff, phase_snap_ff);
  wire logic launch = frame_mark & echo_pend_ff;
  wire logic nxt_echo_valid = launch | (echo_valid_ff & ~slot1_in);

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // modifier held at reset value
  // hertz field held at reset value
  always_ff @(posedge clk_in) begin
    if (hold_all) begin
      rate_mod_ff <= RST_RATE_MOD;
      rate_hz_ff  <= RST_RATE_HZ;
    end else if (ce_in) begin
      rate_mod_ff <= nxt_rate_mod;
      rate_hz_ff  <= nxt_rate_hz;
    end
  end

  // phase cleared while held or disabled
  always_ff @(posedge clk_in) begin
    if (hold_ph) begin
      phase_ff      <= RST_PHASE;
      phase_snap_ff <= RST_PHASE;
    end else if (ce_in) begin
      phase_ff <= nxt_phase;
      if (frame_mark) begin
        phase_snap_ff <= phase_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // Generator core
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (hold_all) begin
      acc_ff     <= ACC_ZERO;
      pre_ff     <= CNT_ZERO;
      div_cnt_ff <= CNT_ZERO;
      conv_ff    <= 1'b0;
      lock_ff    <= 1'b0;
    end else if (ce_in) begin
      if (crystal_clock_input_in) begin
        acc_ff <= nxt_acc;
        pre_ff <= pre_ff + CNT_ONE;
      end
      div_cnt_ff <= nxt_div_cnt;
      conv_ff    <= conv_now;
      lock_ff    <= video;
    end
  end

  // ---------------------------------------------------------------
  // Read port and write echo
  // ---------------------------------------------------------------
  // echo prior contents next frame
  // A new write while an echo waits replaces it; the host is
  // expected to issue at most one write per frame.
  always_ff @(posedge clk_in) begin
    if (hold_all) begin
      echo_hold_ff  <= WORD_ZERO;
      echo_pend_ff  <= 1'b0;
      echo_data_ff  <= WORD_ZERO;
      echo_valid_ff <= 1'b0;
      rd_data_ff    <= WORD_ZERO;
    end else if (ce_in) begin
      rd_data_ff    <= nxt_rd_data;
      echo_valid_ff <= nxt_echo_valid;
      if (launch) begin
        echo_data_ff <= echo_hold_ff;
      end
      if (any_wr) begin
        echo_hold_ff <= prior;
      end
      echo_pend_ff <= any_wr | (echo_pend_ff & ~frame_mark);
    end
  end

  assign rd_data_out    = rd_data_ff;
  assign echo_data_out  = echo_data_ff;
  assign echo_valid_out = echo_valid_ff;
  assign conv_pulse_out = conv_ff;
  assign lock_mode_out  = lock_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_mod_hold;
    @(posedge clk_in) disable iff (rst_in)
      hold_all |=> rate_mod_ff == RST_RATE_MOD;
  endproperty
  a_mod_hold: assert property (p_mod_hold) else $error("modifier not held");
  property p_rate_hold;
    @(posedge clk_in) disable iff (rst_in)
      hold_all |=> rate_hz_ff == RST_RATE_HZ;
  endproperty
  a_rate_hold: assert property (p_rate_hold) else $error("hertz field not held");
  property p_phase_clear;
    @(posedge clk_in) disable iff (rst_in)
      hold_ph |=> phase_ff == RST_PHASE;
  endproperty
  a_phase_clear: assert property (p_phase_clear) else $error("phase not cleared");
  property p_drain;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && ph_apply && !wr_ph && !hold_ph
      |=> phase_magnitude == $past(phase_magnitude) - MAG_ONE;
  endproperty
  a_drain: assert property (p_drain) else $error("magnitude did not drop by one");
  property p_phase_wr;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && wr_ph && !hold_ph
      |=> phase_ff == $past(ctrl_in.data[8:0]);
  endproperty
  a_phase_wr: assert property (p_phase_wr) else $error("phase write not taken");
  property p_echo;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && launch && !hold_all
      |=> echo_valid_out && echo_data_out == $past(echo_hold_ff);
  endproperty
  a_echo: assert property (p_echo) else $error("prior contents not echoed");
  property p_snap;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && frame_mark && !hold_ph
      ##1 ce_in && !hold_all && rd_addr_in == ADDR_PHASE
      |=> rd_data_out == {7'h00, $past(phase_ff, 2)};
  endproperty
  a_snap: assert property (p_snap) else $error("phase read is not the snapshot");
  property p_lock;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !hold_all |=> lock_mode_out == $past(video);
  endproperty
  a_lock: assert property (p_lock) else $error("lock mode does not follow enables");
  property p_div;
    @(posedge clk_in) disable iff (rst_in)
      ce_in && !hold_all && video && base_pulse && !div_hit
      |=> !conv_pulse_out;
  endproperty
  a_div: assert property (p_div) else $error("conversion pulse before divisor count");

  c_video: cover property (@(posedge clk_in) video && conv_ff);
  c_drain: cover property (@(posedge clk_in) ph_apply && phase_direction);
  c_echo:  cover property (@(posedge clk_in) echo_valid_ff && slot1_in);
endmodule
`default_nettype wire

// *** tb/host_dsp_model.sv ***
/*
  Host side model: crystal ticks, frame marks and control accesses.
  Assumes one clock shared with the generator and the package cg3_pkg.
*/
`timescale 1ns/1ns
`default_nettype none
module host_dsp_model (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Timing marks
  output var logic              xtal_out,
  output var logic              slot0_out,
  output var logic              ts_pulse_out,
  output var logic              slot1_out,
  // Control access
  output var cg3_pkg::ctrl_wr_t ctrl_out,
  output var logic [4:0]        rd_addr_out,
  input  wire logic [15:0]      rd_data_in
);
  import cg3_pkg::*;
  logic [5:0] slot_ff;

  initial begin
    slot_ff = 6'h00;
    xtal_out = 1'b0;
    slot0_out = 1'b0;
    ts_pulse_out = 1'b0;
    slot1_out = 1'b0;
    ctrl_out = '0;
    rd_addr_out = 5'h00;
  end

  // A 64-cycle frame keeps echo waits short; a tick every other cycle.
  always @(posedge clk_in) begin
    slot_ff <= rst_in ? 6'h00 : slot_ff + 6'h01;
    xtal_out <= ~rst_in & ~xtal_out;
    slot0_out <= ~rst_in && slot_ff == 6'h3f;
    ts_pulse_out <= ~rst_in && slot_ff == 6'h3f;
    slot1_out <= ~rst_in && slot_ff == 6'h0f;
  end

  // Word write; the request stands for exactly one taken edge.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_in);
    ctrl_out <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_in);
    ctrl_out.wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_in);
    rd_addr_out <= a;
    repeat (2) @(posedge clk_in);
    #1;
    d = rd_data_in;
    // Return on an edge so that the caller's next drive lands there.
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// *** tb/tb_sample_clock_gen_rate_phase_ctrl.sv ***
/*
  Self-checking bench: reset values, holds, echo, direct and video-lock
  rates and phase shift. Assumes tb/host_dsp_model.sv and cg3_pkg.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_sample_clock_gen_rate_phase_ctrl;
  import cg3_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce_in = 1'b1;
  logic        reset_pin_n = 1'b1;
  logic        power_down_pin_n = 1'b1;
  logic        gen_enable = 1'b1;
  logic        bus_master = 1'b1;
  logic        xtal, slot0, ts_pulse, slot1;
  ctrl_wr_t    ctrl;
  logic [4:0]  rd_addr;
  logic [15:0] rd_data, echo_data;
  logic        echo_valid, conv_pulse, lock_mode;
  int          num_errors = 0;
  int          num_checks = 0;
  logic [15:0] rd_data_hold;

  always #5 clk_in = ~clk_in;

  host_dsp_model u_host (.clk_in(clk_in), .rst_in(rst_in), .xtal_out(xtal),
    .slot0_out(slot0), .ts_pulse_out(ts_pulse), .slot1_out(slot1), .ctrl_out(ctrl),
    .rd_addr_out(rd_addr), .rd_data_in(rd_data));

  sample_clock_gen u_dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .reset_pin_n_in(reset_pin_n), .power_down_pin_n_in(power_down_pin_n),
    .generator_enable_in(gen_enable), .crystal_clock_input_in(xtal),
    .bus_master_in(bus_master), .slot0_start_in(slot0),
    .time_slot_input_pulse_in(ts_pulse), .slot1_in(slot1), .ctrl_in(ctrl),
    .rd_addr_in(rd_addr), .rd_data_out(rd_data), .echo_data_out(echo_data),
    .echo_valid_out(echo_valid), .conv_pulse_out(conv_pulse),
    .lock_mode_out(lock_mode));

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_rng(input string what, input logic [15:0] lo, input logic [15:0] hi,
                         input logic [15:0] g);
    num_checks++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      num_errors++;
      $display("unexpected %s expected %0d to %0d seen %0d", what, lo, hi, g);
    end
  endtask

  task automatic rd_chk(input string what, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_host.rd(a, d);
    chk(what, e, d);
  endtask

  // Sums n conversion intervals, in crystal ticks.
  task automatic ticks(input int n, output int t);
    int c;
    t = 0;
    repeat (n) begin
      c = 0;
      do begin
        @(posedge clk_in);
        #1;
        c++;
      end while (conv_pulse !== 1'b1 && c < 20000);
      t += c;
    end
    t = t / 2;
  endtask

  task automatic rate_check(input string what, input int hz);
    int t;
    ticks(2, t);
    ticks(1, t);
    chk_rng(what, 16'(24576000 / hz), 16'(24576000 / hz + 1), t[15:0]);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk("modifier reset", ADDR_RATE_MOD, 16'h00ff);
    rd_chk("hertz reset", ADDR_RATE_HZ, 16'hbb80);
    rd_chk("phase reset", ADDR_PHASE, 16'h0000);
    rd_chk("unmapped read", 5'h05, 16'h0000);
    chk("lock mode reset", 16'h0000, {15'h0000, lock_mode});
    $display("done reset");
  endtask

  task automatic t_rate;
    int n;
    u_host.wr(ADDR_RATE_HZ, 16'h7d00);
    for (n = 0; n < 200 && echo_valid !== 1'b1; n++) @(posedge clk_in);
    #1;
    chk("echo data", 16'hbb80, echo_data);
    for (n = 0; n < 100 && echo_valid === 1'b1; n++) @(posedge clk_in);
    #1;
    chk("echo release", 16'h0000, {15'h0000, echo_valid});
    rd_chk("hertz value", ADDR_RATE_HZ, 16'h7d00);
    // A write while the clock enable is low must be lost.
    ce_in <= 1'b0;
    u_host.wr(ADDR_RATE_HZ, 16'h5555);
    ce_in <= 1'b1;
    rd_chk("hertz frozen", ADDR_RATE_HZ, 16'h7d00);
    rate_check("direct rate", 32000);
    $display("done rate");
  endtask

  task automatic t_phase;
    u_host.wr(ADDR_PHASE, 16'h01ff);
    bus_master <= 1'b0;
    repeat (100) @(posedge clk_in);
    u_host.rd(ADDR_PHASE, rd_data_hold);
    chk_rng("phase in flight", 16'h01f0, 16'h01fe, rd_data_hold);
    u_host.wr(ADDR_PHASE, 16'h0003);
    repeat (200) @(posedge clk_in);
    rd_chk("phase replaced", ADDR_PHASE, 16'h0000);
    gen_enable <= 1'b0;
    u_host.wr(ADDR_PHASE, 16'h0055);
    gen_enable <= 1'b1;
    repeat (70) @(posedge clk_in);
    rd_chk("phase disabled", ADDR_PHASE, 16'h0000);
    bus_master <= 1'b1;
    $display("done phase");
  endtask

  task automatic t_drift;
    int t;
    u_host.wr(ADDR_RATE_HZ, 16'hbb80);
    ticks(2, t);
    u_host.wr(ADDR_PHASE, 16'h00ff);
    ticks(4, t);
    chk_rng("advanced span", 16'd2003, 16'd2006, t[15:0]);
    u_host.wr(ADDR_PHASE, 16'h01ff);
    ticks(4, t);
    chk_rng("retarded span", 16'd2089, 16'd2094, t[15:0]);
    rd_chk("phase drained", ADDR_PHASE, 16'h0100);
    $display("done drift");
  endtask

  task automatic t_hold(input logic pin);
    u_host.wr(ADDR_RATE_HZ, 16'h1234);
    u_host.wr(ADDR_RATE_MOD, 16'h00a5);
    u_host.wr(ADDR_PHASE, 16'h0080);
    if (pin) reset_pin_n <= 1'b0;
    else power_down_pin_n <= 1'b0;
    u_host.wr(ADDR_RATE_HZ, 16'h2222);
    reset_pin_n <= 1'b1;
    power_down_pin_n <= 1'b1;
    repeat (70) @(posedge clk_in);
    rd_chk("hertz after hold", ADDR_RATE_HZ, 16'hbb80);
    rd_chk("modifier after hold", ADDR_RATE_MOD, 16'h00ff);
    rd_chk("phase after hold", ADDR_PHASE, 16'h0000);
    $display("done hold");
  endtask

  task automatic t_video;
    // only offered base and divisor pairs are programmed.
    logic [7:0] mods [12] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50,
                              8'h01, 8'h03, 8'h80, 8'h90, 8'ha0, 8'hb0};
    int hz [12] = '{48000, 32000, 44100, 29400, 48000 * 1000 / 1001, 44056,
                    24000, 12000, 48000, 32000, 44100, 29400};
    for (int i = 0; i < 12; i++) begin
      u_host.wr(ADDR_RATE_MOD, {8'hc0, mods[i]});
      rd_chk("modifier value", ADDR_RATE_MOD, {8'hc0, mods[i]});
      rate_check("video rate", hz[i]);
      chk("lock mode on", 16'h0001, {15'h0000, lock_mode});
    end
    u_host.wr(ADDR_RATE_MOD, 16'h4000);
    repeat (2) @(posedge clk_in);
    #1;
    chk("lock mode off", 16'h0000, {15'h0000, lock_mode});
    $display("done video");
  endtask

  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_rate;
    t_phase;
    t_drift;
    t_hold(1'b1);
    t_hold(1'b0);
    t_video;
    close_out;
  end

  // The planned run is near 75000 cycles; a hang is stopped short of 100000.
  initial begin
    repeat (95000) @(posedge clk_in);
    num_errors++;
    $display("unexpected run length expected finish seen timeout");
    close_out;
  end
endmodule
`default_nettype wire
